/* File: pkg/gpio_toggle_sink_tx_pkg.sv */
// constants and types shared by the gpio, toggle and sink transmit register bank
package gpio_toggle_sink_tx_pkg;
    // register offsets
    localparam logic [7:0] PIN1_CONFIG_ADDR = 8'ha4;
    localparam logic [7:0] PIN2_CONFIG_ADDR = 8'ha5;
    localparam logic [7:0] PIN_INPUT_STATUS_ADDR = 8'ha6;
    localparam logic [7:0] ROLE_TOGGLE_TIMING_ADDR = 8'ha7;
    localparam logic [7:0] SINK_TX_CONTROL_ADDR = 8'hb0;
    localparam logic [7:0] SOURCE_SWAP_ADDR = 8'hb1;

    // reset values
    localparam logic [7:0] PIN1_CONFIG_RESET = 8'h00;
    localparam logic [7:0] PIN2_CONFIG_RESET = 8'h00;
    localparam logic [7:0] PIN_INPUT_STATUS_RESET = 8'h00;
    localparam logic [7:0] ROLE_TOGGLE_TIMING_RESET = 8'h00;
    localparam logic [7:0] SINK_TX_CONTROL_RESET = 8'h40;
    localparam logic [7:0] SOURCE_SWAP_RESET = 8'h00;

    // writable bits of each configuration register
    localparam logic [7:0] PIN1_CONFIG_MASK = 8'h07;
    localparam logic [7:0] PIN2_CONFIG_MASK = 8'h0f;
    localparam logic [7:0] ROLE_TOGGLE_TIMING_MASK = 8'h03;
    localparam logic [7:0] SINK_TX_CONTROL_MASK = 8'h77;

    // field positions
    localparam int OUT_ENABLE_BIT = 0;
    localparam int IN_ENABLE_BIT = 1;
    localparam int OUT_LEVEL_BIT = 2;
    localparam int SWAP_FUNCTION_BIT = 3;
    localparam int PIN1_LEVEL_BIT = 0;
    localparam int PIN2_LEVEL_BIT = 1;
    localparam int SINK_TX_DISABLE_BIT = 6;
    localparam int RETRY_LSB = 4;
    localparam int FRAME_LSB = 0;
    localparam int SWAP_REQUEST_BIT = 0;

    // transmit frame type codes
    localparam logic [2:0] FRAME_SOP = 3'h0;
    localparam logic [2:0] FRAME_SOP_DBG2 = 3'h4;
    localparam logic [2:0] FRAME_HARD_RESET_A = 3'h5;
    localparam logic [2:0] FRAME_HARD_RESET_B = 3'h6;
    localparam logic [2:0] FRAME_CABLE_RESET = 3'h7;

    // advertised source current seen on the cc line
    localparam logic [1:0] RP_DEFAULT = 2'h1;
    localparam logic [1:0] RP_1A5 = 2'h2;
    localparam logic [1:0] RP_3A0 = 2'h3;

    // toggle phase minimum times in ms, the maximum is twice the minimum
    localparam logic [6:0] TOGGLE_SRC_MIN_MS0 = 7'h0f;
    localparam logic [6:0] TOGGLE_SRC_MIN_MS1 = 7'h14;
    localparam logic [6:0] TOGGLE_SRC_MIN_MS2 = 7'h19;
    localparam logic [6:0] TOGGLE_SRC_MIN_MS3 = 7'h1e;
    localparam logic [6:0] TOGGLE_SNK_MIN_MS0 = 7'h23;
    localparam logic [6:0] TOGGLE_SNK_MIN_MS1 = 7'h1e;
    localparam logic [6:0] TOGGLE_SNK_MIN_MS2 = 7'h19;
    localparam logic [6:0] TOGGLE_SNK_MIN_MS3 = 7'h14;

    // swap signalling must start within this time of a pin 2 falling edge
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int SWAP_SEND_TIME_NS = 100;
    localparam int SWAP_SEND_CYCLES = SWAP_SEND_TIME_NS / CLOCK_PERIOD_NS;

    // what the transmitter is asked to send
    typedef enum logic [1:0] {TX_MESSAGE, TX_HARD_RESET, TX_CABLE_RESET} tx_kind_t;
endpackage

/* File: rtl/pin_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 2
) (
    // clocking
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    // pins and result
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] firstStage;

    // first stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (reset) begin
            firstStage <= '0;
            synced <= '0;
        end else if (clockEnable) begin
            firstStage <= async;
            synced <= firstStage;
        end
    end
endmodule

/* File: rtl/gpio_toggle_sink_tx_regs.sv */
// gpio, toggle timing and sink transmit register bank of a type-c port controller
//
// Summary of operation
// - pin 1 high impedance unless output enabled; then driven to its level bit.
// - pin 1 input enable lets its sampled level show in the status register.
// - pin 2 generic output: enabled drives level bit, disabled is high impedance.
// - pin 2 swap function bit selects fast role swap use over generic use.
// - in sink swap use a vbus disconnect drives pin 2 low automatically.
// - generic pin 2 input enable lets its sampled level show in status.
// - swap monitor mode: pin 2 falling edge starts swap signalling within send time.
// - status bit 1 is pin 2 level, bit 0 pin 1 level.
// - two-bit toggle select sets source and sink toggle phase times.
// - sink write arms a transmit that starts when rp rises from 1.5 a to 3.0 a.
// - hard reset and cable reset ignore retry count and are sent once.
// - sink tx disable bit 6 blocks sink transmit; reset value 0x40.
// - retry count bits 5:4 give zero to three automatic retries.
// - frame type bits 2:0 select sop, sop', sop'', sop_dbg', sop_dbg''.
// - frame codes 101b and 110b both send hard reset.
// - frame code 111b sends cable reset.
// - writing swap request one starts fast role swap and clears itself.
`timescale 1ns/1ns
module gpio_toggle_sink_tx_regs
    import gpio_toggle_sink_tx_pkg::*;
(
    // clocking
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // general purpose pins
    input wire logic pin1In,
    output logic pin1Out,
    output logic pin1OutEnableN,
    input wire logic pin2In,
    output logic pin2Out,
    output logic pin2OutEnableN,
    // port state from the type-c logic
    input wire logic isSink,
    input wire logic [1:0] rpAdvert,
    input wire logic vbusDisconnect,
    // toggle timing
    output logic [6:0] sourcePhaseMinMs,
    output logic [6:0] sinkPhaseMinMs,
    // transmitter requests
    output logic swapSignalStart,
    output logic txStart,
    output logic [2:0] txFrame,
    output tx_kind_t txKind,
    output logic [1:0] txRetries
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] pin1Config;
    logic [7:0] pin2Config;
    logic [7:0] pinInputStatus;
    logic [7:0] roleToggleTiming;
    logic [7:0] sinkTxControl;
    logic sourceSwap;
    logic [1:0] pinLevels;
    logic pin2LevelOld;
    logic swapDropped;
    logic txArmed;
    logic [1:0] rpOld;
    logic rpRise;
    logic pin2Fall;
    logic monitorMode;
    logic [2:0] frameType;

    function automatic logic isWrite(input logic [7:0] addr, input logic [7:0] target);
        return regWrite && (addr == target);
    endfunction

    // minimum toggle phase time for source or sink at a given select code
    function automatic logic [6:0] phaseMin(input logic [1:0] sel, input logic sink);
        logic [6:0] ms;
        ms = 7'h00;
        case (sel)
            2'h0: ms = sink ? TOGGLE_SNK_MIN_MS0 : TOGGLE_SRC_MIN_MS0;
            2'h1: ms = sink ? TOGGLE_SNK_MIN_MS1 : TOGGLE_SRC_MIN_MS1;
            2'h2: ms = sink ? TOGGLE_SNK_MIN_MS2 : TOGGLE_SRC_MIN_MS2;
            default: ms = sink ? TOGGLE_SNK_MIN_MS3 : TOGGLE_SRC_MIN_MS3;
        endcase
        return ms;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pins come from outside the clock domain
    pin_sync #(.WIDTH(2)) pinSync (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .async({pin2In, pin1In}),
        .synced(pinLevels)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; reserved bits masked off
    always_ff @(posedge clock) begin
        if (reset) begin
            pin1Config <= PIN1_CONFIG_RESET;
            pin2Config <= PIN2_CONFIG_RESET;
            roleToggleTiming <= ROLE_TOGGLE_TIMING_RESET;
            sinkTxControl <= SINK_TX_CONTROL_RESET;
        end else if (clockEnable) begin
            if (isWrite(regAddr, PIN1_CONFIG_ADDR))
                pin1Config <= regWriteData & PIN1_CONFIG_MASK;
            if (isWrite(regAddr, PIN2_CONFIG_ADDR))
                pin2Config <= regWriteData & PIN2_CONFIG_MASK;
            if (isWrite(regAddr, ROLE_TOGGLE_TIMING_ADDR))
                roleToggleTiming <= regWriteData & ROLE_TOGGLE_TIMING_MASK;
            if (isWrite(regAddr, SINK_TX_CONTROL_ADDR))
                sinkTxControl <= regWriteData & SINK_TX_CONTROL_MASK;
        end
    end

    // swap request: write sets, hardware clears one cycle later
    always_ff @(posedge clock) begin
        if (reset) begin
            sourceSwap <= SOURCE_SWAP_RESET[SWAP_REQUEST_BIT];
        end else if (clockEnable) begin
            if (isWrite(regAddr, SOURCE_SWAP_ADDR) && regWriteData[SWAP_REQUEST_BIT])
                sourceSwap <= 1'b1;
            else
                sourceSwap <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input status; a disabled buffer reads low
    always_ff @(posedge clock) begin
        if (reset) begin
            pinInputStatus <= PIN_INPUT_STATUS_RESET;
        end else if (clockEnable) begin
            pinInputStatus <= 8'h00;
            pinInputStatus[PIN1_LEVEL_BIT] <= pinLevels[0] & pin1Config[IN_ENABLE_BIT];
            pinInputStatus[PIN2_LEVEL_BIT] <= pinLevels[1] & pin2Config[IN_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers; enables are active low
    always_ff @(posedge clock) begin
        if (reset) begin
            pin1Out <= 1'b0;
            pin1OutEnableN <= 1'b1;
            pin2Out <= 1'b0;
            pin2OutEnableN <= 1'b1;
        end else if (clockEnable) begin
            pin1OutEnableN <= ~pin1Config[OUT_ENABLE_BIT];
            pin1Out <= pin1Config[OUT_LEVEL_BIT];
            pin2OutEnableN <= ~pin2Config[OUT_ENABLE_BIT];
            if (pin2Config[SWAP_FUNCTION_BIT])
                pin2Out <= pin2Config[OUT_LEVEL_BIT] & ~swapDropped & ~vbusDisconnect;
            else
                pin2Out <= pin2Config[OUT_LEVEL_BIT];
        end
    end

    // a disconnect keeps pin 2 low until software rewrites pin2_config
    always_ff @(posedge clock) begin
        if (reset) begin
            swapDropped <= 1'b0;
        end else if (clockEnable) begin
            if (vbusDisconnect && pin2Config[SWAP_FUNCTION_BIT] && pin2Config[OUT_ENABLE_BIT])
                swapDropped <= 1'b1;
            else if (isWrite(regAddr, PIN2_CONFIG_ADDR))
                swapDropped <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // swap monitor on pin 2
    assign monitorMode = pin2Config[SWAP_FUNCTION_BIT] & ~pin2Config[OUT_ENABLE_BIT]
        & pin2Config[IN_ENABLE_BIT];
    assign pin2Fall = pin2LevelOld & ~pinLevels[1];

    always_ff @(posedge clock) begin
        if (reset) begin
            pin2LevelOld <= 1'b0;
            swapSignalStart <= 1'b0;
        end else if (clockEnable) begin
            pin2LevelOld <= pinLevels[1];
            // one cycle after the synchroniser, well inside the send time
            swapSignalStart <= (monitorMode & pin2Fall) | sourceSwap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // toggle timing
    always_ff @(posedge clock) begin
        if (reset) begin
            sourcePhaseMinMs <= TOGGLE_SRC_MIN_MS0;
            sinkPhaseMinMs <= TOGGLE_SNK_MIN_MS0;
        end else if (clockEnable) begin
            sourcePhaseMinMs <= phaseMin(roleToggleTiming[1:0], 1'b0);
            sinkPhaseMinMs <= phaseMin(roleToggleTiming[1:0], 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sink transmit: armed by a write, fired on the rp step from 1.5 a to 3.0 a
    assign rpRise = (rpOld == RP_1A5) && (rpAdvert == RP_3A0);
    assign frameType = sinkTxControl[FRAME_LSB +: 3];

    always_ff @(posedge clock) begin
        if (reset) begin
            rpOld <= RP_DEFAULT;
        end else if (clockEnable) begin
            rpOld <= rpAdvert;
        end
    end

    // a write in the source role is not expected and is not armed
    always_ff @(posedge clock) begin
        if (reset) begin
            txArmed <= 1'b0;
        end else if (clockEnable) begin
            if (isWrite(regAddr, SINK_TX_CONTROL_ADDR) && isSink
                    && !regWriteData[SINK_TX_DISABLE_BIT])
                txArmed <= 1'b1;
            else if (rpRise || !isSink || sinkTxControl[SINK_TX_DISABLE_BIT])
                txArmed <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            txStart <= 1'b0;
            txFrame <= FRAME_SOP;
            txKind <= TX_MESSAGE;
            txRetries <= 2'h0;
        end else if (clockEnable) begin
            txStart <= txArmed & rpRise & isSink & ~sinkTxControl[SINK_TX_DISABLE_BIT];
            txFrame <= frameType;
            case (frameType)
                FRAME_HARD_RESET_A, FRAME_HARD_RESET_B: begin
                    txKind <= TX_HARD_RESET;
                    txRetries <= 2'h0;
                end
                FRAME_CABLE_RESET: begin
                    txKind <= TX_CABLE_RESET;
                    txRetries <= 2'h0;
                end
                default: begin
                    txKind <= TX_MESSAGE;
                    txRetries <= sinkTxControl[RETRY_LSB +: 2];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, one cycle latency; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            regReadData <= 8'h00;
        end else if (clockEnable && regRead) begin
            case (regAddr)
                PIN1_CONFIG_ADDR: regReadData <= pin1Config;
                PIN2_CONFIG_ADDR: regReadData <= pin2Config;
                PIN_INPUT_STATUS_ADDR: regReadData <= pinInputStatus;
                ROLE_TOGGLE_TIMING_ADDR: regReadData <= roleToggleTiming;
                SINK_TX_CONTROL_ADDR: regReadData <= sinkTxControl;
                SOURCE_SWAP_ADDR: regReadData <= {7'h00, sourceSwap};
                default: regReadData <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    pin1_drive_a: assert property (@(posedge clock) disable iff (reset)
        clockEnable |=> (pin1OutEnableN == ~$past(pin1Config[OUT_ENABLE_BIT])))
        else $error("pin 1 enable does not follow config");

    pin1_status_a: assert property (@(posedge clock) disable iff (reset)
        !pin1Config[IN_ENABLE_BIT] && clockEnable |=> !pinInputStatus[PIN1_LEVEL_BIT])
        else $error("disabled pin 1 input reads high");

    pin2_generic_a: assert property (@(posedge clock) disable iff (reset)
        clockEnable && !pin2Config[SWAP_FUNCTION_BIT] |=> pin2Out == $past(pin2Config[OUT_LEVEL_BIT]))
        else $error("pin 2 generic level wrong");

    swap_drop_a: assert property (@(posedge clock) disable iff (reset)
        clockEnable && vbusDisconnect && pin2Config[SWAP_FUNCTION_BIT] |=> !pin2Out)
        else $error("pin 2 not driven low on disconnect");

    swap_start_a: assert property (@(posedge clock) disable iff (reset)
        clockEnable && monitorMode && pin2Fall |=> swapSignalStart)
        else $error("swap signalling not started");

    reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
        (sinkTxControl[7] == 1'b0) && (sinkTxControl[3] == 1'b0) && (pin2Config[7:4] == 4'h0))
        else $error("reserved bit set");

    once_only_a: assert property (@(posedge clock) disable iff (reset)
        txStart && txKind != TX_MESSAGE |-> txRetries == 2'h0)
        else $error("reset signalling with retries");

    tx_disabled_a: assert property (@(posedge clock) disable iff (reset)
        sinkTxControl[SINK_TX_DISABLE_BIT] && clockEnable |=> !txStart)
        else $error("transmit while disabled");

    tx_trigger_a: assert property (@(posedge clock) disable iff (reset)
        clockEnable ##1 txStart |-> $past(rpRise) && $past(txArmed))
        else $error("transmit without rp rise");

    swap_clear_a: assert property (@(posedge clock) disable iff (reset)
        clockEnable && sourceSwap |=> !sourceSwap ##0 swapSignalStart)
        else $error("swap request not cleared");

    tx_fire_c: cover property (@(posedge clock) disable iff (reset) txStart);
    swap_pin_c: cover property (@(posedge clock) disable iff (reset) monitorMode ##1 swapSignalStart);
    drop_c: cover property (@(posedge clock) disable iff (reset) swapDropped && !pin2OutEnableN);
endmodule

/* File: tb/pin_partner.sv */
// board model of the two general purpose pins and what drives them from outside
`timescale 1ns/1ns
module pin_partner (
    // device side
    input wire logic pin1Out,
    input wire logic pin1OutEnableN,
    input wire logic pin2Out,
    input wire logic pin2OutEnableN,
    // external driver on the board
    input wire logic extDrive1,
    input wire logic extLevel1,
    input wire logic extDrive2,
    input wire logic extLevel2,
    // resolved pin levels
    output logic pin1Wire,
    output logic pin2Wire
);
    ////////////////////////////////////////
    // released pins follow the external driver when it drives, else fall to the board pull-up, so a stale driven level never lingers
    assign pin1Wire = !pin1OutEnableN ? pin1Out : (extDrive1 ? extLevel1 : 1'b1);
    assign pin2Wire = !pin2OutEnableN ? pin2Out : (extDrive2 ? extLevel2 : 1'b1);
endmodule

/* File: tb/gpio_toggle_sink_tx_regs_tb_top.sv */
// self-checking bench for the gpio, toggle timing and sink transmit register bank
`timescale 1ns/1ns
module gpio_toggle_sink_tx_regs_tb_top
    import gpio_toggle_sink_tx_pkg::*;
;
    logic clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, clockEnable = 1'b1;
    logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, regReadData;
    logic pin1Out, pin1OutEnableN, pin2Out, pin2OutEnableN, pin1Wire, pin2Wire;
    logic extDrive1 = 1'b0, extLevel1 = 1'b1, extDrive2 = 1'b0, extLevel2 = 1'b1;
    logic isSink = 1'b0, vbusDisconnect = 1'b0, swapSignalStart, txStart;
    logic [1:0] rpAdvert = RP_DEFAULT, txRetries;
    logic [6:0] sourcePhaseMinMs, sinkPhaseMinMs;
    logic [2:0] txFrame;
    tx_kind_t txKind;
    int num_errors = 0, cmp_count = 0;

    always #10 clock = ~clock;

    gpio_toggle_sink_tx_regs dut (.clock(clock), .reset(reset), .clockEnable(clockEnable), .regAddr(regAddr),
        .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
        .pin1In(pin1Wire), .pin1Out(pin1Out), .pin1OutEnableN(pin1OutEnableN), .pin2In(pin2Wire),
        .pin2Out(pin2Out), .pin2OutEnableN(pin2OutEnableN), .isSink(isSink), .rpAdvert(rpAdvert),
        .vbusDisconnect(vbusDisconnect), .sourcePhaseMinMs(sourcePhaseMinMs), .sinkPhaseMinMs(sinkPhaseMinMs),
        .swapSignalStart(swapSignalStart), .txStart(txStart), .txFrame(txFrame), .txKind(txKind),
        .txRetries(txRetries));

    pin_partner board (.pin1Out(pin1Out), .pin1OutEnableN(pin1OutEnableN), .pin2Out(pin2Out),
        .pin2OutEnableN(pin2OutEnableN), .extDrive1(extDrive1), .extLevel1(extLevel1),
        .extDrive2(extDrive2), .extLevel2(extLevel2), .pin1Wire(pin1Wire), .pin2Wire(pin2Wire));

    ////////////////////////////////////////
    // inputs always change 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strobe drops and an idle edge passes, so back-to-back calls never retrigger in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
        tick(1);
    endtask

    task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        regRead = 1'b1;
        tick(1);
        regRead = 1'b0;
        check(what, exp, regReadData);
        tick(1);
    endtask

    task automatic wait_pulse(input bit tx, input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            if ((tx ? txStart : swapSignalStart) === 1'b1) seen = 1'b1;
            tick(1);
        end
    endtask

    ////////////////////////////////////////
    task automatic test_registers();
        logic [7:0] addrs [6] = '{PIN_INPUT_STATUS_ADDR, 8'ha4, 8'ha5, 8'ha7, 8'hb0, 8'ha8};
        logic [7:0] resets [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
        logic [7:0] kept [6] = '{8'h00, 8'h07, 8'h0f, 8'h03, 8'h77, 8'h00};
        check("pin1 enable after reset", 8'h01, {7'h0, pin1OutEnableN});
        check("pin2 enable after reset", 8'h01, {7'h0, pin2OutEnableN});
        for (int i = 0; i < 6; i++) rd_check("reset value", addrs[i], resets[i]);
        for (int i = 0; i < 6; i++) begin
            wr(addrs[i], 8'hff);
            rd_check("writable bits", addrs[i], kept[i]);
        end
        wr(8'ha4, 8'h00);
        wr(8'ha5, 8'h00);
        wr(8'hb0, 8'h40);
        $display("test registers done");
    endtask

    task automatic test_generic_pin(input bit two);
        logic [7:0] a = two ? PIN2_CONFIG_ADDR : PIN1_CONFIG_ADDR;
        logic [7:0] st = two ? 8'h02 : 8'h01;
        wr(a, 8'h05);
        check("pin out high", 8'h01, {7'h0, two ? pin2Out : pin1Out});
        check("pin driving", 8'h00, {7'h0, two ? pin2OutEnableN : pin1OutEnableN});
        wr(a, 8'h01);
        check("pin out low", 8'h00, {7'h0, two ? pin2Out : pin1Out});
        wr(a, 8'h04);
        check("pin released", 8'h01, {7'h0, two ? pin2OutEnableN : pin1OutEnableN});
        wr(a, 8'h02);
        {extDrive1, extLevel1, extDrive2, extLevel2} = two ? 4'b0110 : 4'b1001;
        tick(3);
        rd_check("status pin low", PIN_INPUT_STATUS_ADDR, 8'h00);
        {extDrive1, extDrive2} = 2'b00;
        tick(3);
        rd_check("status pin high", PIN_INPUT_STATUS_ADDR, st);
        wr(a, 8'h00);
        rd_check("status buffer off", PIN_INPUT_STATUS_ADDR, 8'h00);
        $display("test generic pin %0d done", two + 1);
    endtask

    task automatic test_swap();
        logic seen;
        wr(PIN2_CONFIG_ADDR, 8'h0d);
        check("swap drive level", 8'h01, {7'h0, pin2Out});
        vbusDisconnect = 1'b1;
        tick(1);
        check("swap drop", 8'h00, {7'h0, pin2Out});
        vbusDisconnect = 1'b0;
        tick(2);
        check("swap drop held", 8'h00, {7'h0, pin2Out});
        wr(PIN2_CONFIG_ADDR, 8'h0a);
        tick(3);
        {extDrive2, extLevel2} = 2'b10;
        wait_pulse(1'b0, SWAP_SEND_CYCLES + 1, seen);
        check("swap after fall", 8'h01, {7'h0, seen});
        extDrive2 = 1'b0;
        wr(PIN2_CONFIG_ADDR, 8'h00);
        wr(SOURCE_SWAP_ADDR, 8'h01);
        wait_pulse(1'b0, 3, seen);
        check("swap request", 8'h01, {7'h0, seen});
        rd_check("swap request cleared", SOURCE_SWAP_ADDR, 8'h00);
        $display("test swap done");
    endtask

    task automatic test_toggle();
        for (int i = 0; i < 4; i++) begin
            wr(ROLE_TOGGLE_TIMING_ADDR, 8'hfc | 8'(i));
            check("source phase", 8'(15 + 5 * i), {1'b0, sourcePhaseMinMs});
            check("sink phase", 8'(35 - 5 * i), {1'b0, sinkPhaseMinMs});
            rd_check("toggle readback", ROLE_TOGGLE_TIMING_ADDR, 8'(i));
        end
        $display("test toggle done");
    endtask

    // a write while the clock enable is low must leave no trace
    task automatic test_freeze();
        clockEnable = 1'b0;
        wr(PIN1_CONFIG_ADDR, 8'h05);
        check("frozen pin enable", 8'h01, {7'h0, pin1OutEnableN});
        clockEnable = 1'b1;
        rd_check("frozen write", PIN1_CONFIG_ADDR, 8'h00);
        $display("test freeze done");
    endtask

    task automatic test_sink_tx();
        logic seen;
        logic [1:0] r;
        logic [2:0] fr;
        tx_kind_t kind;
        isSink = 1'b1; // only written as sink
        for (int f = 0; f < 8; f++) begin
            fr = f[2:0];
            r = f[1:0] ^ 2'b11;
            kind = fr == 3'h7 ? TX_CABLE_RESET : (fr > 3'h4 ? TX_HARD_RESET : TX_MESSAGE);
            rpAdvert = RP_1A5; // rp steps back down after each message
            wr(SINK_TX_CONTROL_ADDR, {2'b00, r, 1'b0, fr});
            check("tx frame", {5'h0, fr}, {5'h0, txFrame});
            check("tx kind", 8'(kind), 8'(txKind));
            check("tx retries", {6'h0, fr > 3'h4 ? 2'b00 : r}, {6'h0, txRetries});
            rpAdvert = RP_3A0;
            wait_pulse(1'b1, 4, seen);
            check("tx start", 8'h01, {7'h0, seen});
        end
        rpAdvert = RP_1A5;
        wr(SINK_TX_CONTROL_ADDR, 8'h52);
        rpAdvert = RP_3A0;
        wait_pulse(1'b1, 4, seen);
        check("tx blocked", 8'h00, {7'h0, seen});
        isSink = 1'b0;
        $display("test sink transmit done");
    endtask

    ////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    initial begin
        #(20 * 5000);
        num_errors++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        test_registers();
        test_generic_pin(1'b0);
        test_generic_pin(1'b1);
        test_swap();
        test_toggle();
        test_freeze();
        test_sink_tx();
        give_verdict();
    end
endmodule
